// [src/ars_pkg.sv]
package ars_pkg;

   // Register map, byte addresses on the plain register port
   localparam logic [7:0]  ADDR_CFG       = 8'h00;
   localparam logic [7:0]  ADDR_STAT      = 8'h04;
   localparam logic [7:0]  ADDR_WBPTR     = 8'h08;

   // Configuration register fields
   localparam int          CFG_ROUND_BIT  = 0;
   localparam int          CFG_STSAT_BIT  = 1;
   localparam int          CFG_TRAP_BIT   = 2;

   // Status register fields; A and B are write one to clear, AB reads their OR
   localparam int          STAT_A_BIT     = 0;
   localparam int          STAT_B_BIT     = 1;
   localparam int          STAT_AB_BIT    = 2;

   // Values after reset
   localparam logic        CFG_RSEL_RESET = 1'b0;
   localparam logic        CFG_SAT_RESET  = 1'b0;
   localparam logic        CFG_TRAP_RESET = 1'b0;
   localparam logic [15:0] WBPTR_RESET    = 16'h0000;

   // Datapath constants
   localparam logic [15:0] WBPTR_STEP     = 16'h0002;
   localparam logic [15:0] ROUND_HALF     = 16'h8000;
   localparam logic [15:0] SAT_POS        = 16'h7FFF;
   localparam logic [15:0] SAT_NEG        = 16'h8000;
   localparam logic [15:0] UPPER_ALL_ONE  = 16'hFFFF;
   localparam logic [8:0]  GUARD_POS      = 9'h000;
   localparam logic [8:0]  GUARD_NEG      = 9'h1FF;
   localparam logic [5:0]  SH_LIMIT       = 6'h10;

   typedef enum logic [2:0] {
      ARS_OP_MAC    = 3'b000,
      ARS_OP_MSC    = 3'b001,
      ARS_OP_MOVSAC = 3'b010,
      ARS_OP_CLR    = 3'b011,
      ARS_OP_MUL    = 3'b100,
      ARS_OP_MULN   = 3'b101,
      ARS_OP_SQD    = 3'b110,
      ARS_OP_SQDAC  = 3'b111
   } ars_mac_op_t;

   typedef enum logic [1:0] {
      ARS_SRC_ACC_A = 2'b00,
      ARS_SRC_ACC_B = 2'b01,
      ARS_SRC_XBUS  = 2'b10,
      ARS_SRC_NONE  = 2'b11
   } ars_sh_src_t;

   typedef enum logic {
      ARS_WB_DIRECT   = 1'b0,
      ARS_WB_POSTINC  = 1'b1
   } ars_wb_mode_t;

endpackage : ars_pkg

// [src/ars_engine.sv]
`timescale 1ns/1ps
// Function
// RULE1 - Bit 39 overflow sets flag, accumulator wraps
// RULE2 - Trap enable lets overflow request trap
// RULE3 - Non-target write-back except four excluded ops
// RULE4 - Write-back travels X bus, any address
// RULE5 - Direct mode puts word into pointer
// RULE6 - Post-increment stores at pointer, adds two
// RULE7 - Mode bit picks conventional or convergent
// RULE8 - No rounding requested: truncate upper word
// RULE9 - Conventional: lower at least half increments
// RULE10 - Convergent tie increments only if bit16
// RULE11 - Store ops write target truncated or rounded
// RULE12 - Write-back value is always rounded
// RULE13 - Store saturation never alters accumulator
// RULE14 - Saturate above 0x007FFF to 0x7FFF
// RULE15 - Saturate below 0xFF8000 to 0x8000
// RULE16 - Saturation sign taken from bit 39
// RULE17 - Saturation off passes value unchanged
// RULE18 - Shifter: arithmetic, logical, left, up to 16
// RULE19 - Signed amount: positive right, negative left
// RULE20 - Forty-bit shifter, 40 or 16 bit results
// RULE21 - X operand at 31:16 right, 15:0 left
// RULE22 - Flags set by adder, cleared by software
// RULE23 - Round carry out reaches saturation stage
module ars_engine (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_resetn,
   input  wire logic [7:0]           i_reg_addr,
   input  wire logic [31:0]          i_reg_wdata,
   input  wire logic                 i_reg_wr,
   input  wire logic                 i_reg_rd,
   output logic      [31:0]          o_reg_rdata,
   input  wire logic                 i_add_valid,
   input  wire logic                 i_add_target,
   input  wire logic [39:0]          i_add_result,
   input  wire logic                 i_add_ovf39,
   input  wire logic                 i_store_valid,
   input  wire logic                 i_store_round,
   input  wire logic                 i_store_target,
   input  wire logic [15:0]          i_store_addr,
   input  wire logic                 i_mac_valid,
   input  wire ars_pkg::ars_mac_op_t i_mac_op,
   input  wire logic                 i_mac_target,
   input  wire logic                 i_mac_wb_en,
   input  wire ars_pkg::ars_wb_mode_t i_mac_wb_mode,
   input  wire logic                 i_sh_valid,
   input  wire ars_pkg::ars_sh_src_t i_sh_src,
   input  wire logic                 i_sh_arith,
   input  wire logic [5:0]           i_sh_amount,
   input  wire logic [15:0]          i_sh_xdata,
   output logic                      o_xwr_valid,
   output logic      [15:0]          o_xwr_addr,
   output logic      [15:0]          o_xwr_data,
   output logic                      o_trap_req,
   output logic                      o_acc_a_saturation_flag,
   output logic                      o_acc_b_saturation_flag,
   output logic                      o_sh_valid,
   output logic      [39:0]          o_sh_result,
   output logic      [15:0]          o_sh_word
);

   typedef struct packed {
      logic [39:0] acc_a;
      logic [39:0] acc_b;
      logic        round_mode_select;
      logic        store_saturate_enable;
      logic        catastrophic_trap_enable;
      logic        acc_a_saturation_flag;
      logic        acc_b_saturation_flag;
      logic [15:0] writeback_pointer_reg;
      logic [31:0] rdata;
      logic        xwr_valid;
      logic [15:0] xwr_addr;
      logic [15:0] xwr_data;
      logic        trap_req;
      logic        sh_valid;
      logic [39:0] sh_result;
      logic [15:0] sh_word;
   } ars_state_t;

   ars_state_t st;
   ars_state_t next_st;

   // Round and store saturation; a pure function so the accumulator is never touched
   function automatic logic [15:0] ars_store_word(input logic [39:0] acc,
                                                  input logic        do_rnd,
                                                  input logic        conv,
                                                  input logic        sat);
      logic        inc;
      logic [24:0] ext;
      logic        rnd_carry;
      logic        pos_ovf;
      logic        neg_ovf;
      inc = do_rnd & acc[15]
            & (~conv | (acc[15:0] != ars_pkg::ROUND_HALF) | acc[16]);    // [RULE9] [RULE10]
      ext = {acc[39], acc[39:16]} + {24'h000000, inc};                  // [RULE8]
      rnd_carry = inc & (acc[31:16] == ars_pkg::UPPER_ALL_ONE);          // [RULE23]
      pos_ovf = ~acc[39] & ((ext[23:15] != ars_pkg::GUARD_POS) | rnd_carry); // [RULE16]
      // A negative value that rounds up to zero is in range, not clamped
      neg_ovf = acc[39] & ext[24] & (ext[23:15] != ars_pkg::GUARD_NEG);  // [RULE16]
      if (sat & pos_ovf) begin
         return ars_pkg::SAT_POS;                                        // [RULE14]
      end else if (sat & neg_ovf) begin
         return ars_pkg::SAT_NEG;                                        // [RULE15]
      end
      return ext[15:0];                                                  // [RULE17]
   endfunction : ars_store_word

   logic [39:0] store_acc;
   logic [39:0] wb_acc;
   logic [15:0] store_word;
   logic [15:0] wb_word;
   logic        wb_allowed;
   logic [39:0] sh_operand;
   logic [39:0] sh_out;
   logic [4:0]  sh_mag;
   logic        sh_left;
   logic        stat_clr_a;
   logic        stat_clr_b;

   always_comb begin
      store_acc  = i_store_target ? st.acc_b : st.acc_a;
      wb_acc     = i_mac_target ? st.acc_a : st.acc_b;                     // [RULE3]
      store_word = ars_store_word(store_acc, i_store_round, st.round_mode_select,
                                  st.store_saturate_enable);               // [RULE7] [RULE11]
      wb_word    = ars_store_word(wb_acc, 1'b1, st.round_mode_select,
                                  st.store_saturate_enable);               // [RULE12]
      wb_allowed = i_mac_valid & i_mac_wb_en & ~i_store_valid
                   & (i_mac_op != ars_pkg::ARS_OP_MUL)
                   & (i_mac_op != ars_pkg::ARS_OP_MULN)
                   & (i_mac_op != ars_pkg::ARS_OP_SQD)
                   & (i_mac_op != ars_pkg::ARS_OP_SQDAC);                  // [RULE3]
   end

   // Barrel shifter; amounts beyond 16 are clipped rather than wrapped
   always_comb begin
      sh_left = i_sh_amount[5];                                            // [RULE19]
      if (sh_left) begin
         sh_mag = (i_sh_amount == 6'h30) ? 5'h10 : 5'((~i_sh_amount) + 6'h01);
      end else if (i_sh_amount > ars_pkg::SH_LIMIT) begin
         sh_mag = 5'h10;
      end else begin
         sh_mag = i_sh_amount[4:0];
      end
      if (sh_left && (i_sh_amount < 6'h30)) begin
         sh_mag = 5'h10;
      end
      unique case (i_sh_src)
         ars_pkg::ARS_SRC_ACC_A: sh_operand = st.acc_a;
         ars_pkg::ARS_SRC_ACC_B: sh_operand = st.acc_b;
         ars_pkg::ARS_SRC_XBUS: begin
            if (sh_left) begin
               sh_operand = {24'h000000, i_sh_xdata};                      // [RULE21]
            end else begin
               sh_operand = {{8{i_sh_arith & i_sh_xdata[15]}}, i_sh_xdata,
                             16'h0000};                                    // [RULE21]
            end
         end
         default: sh_operand = 40'h0000000000;
      endcase
      if (sh_left) begin
         sh_out = sh_operand << sh_mag;                                    // [RULE18]
      end else if (i_sh_arith) begin
         sh_out = 40'($signed(sh_operand) >>> sh_mag);                     // [RULE18]
      end else begin
         sh_out = sh_operand >> sh_mag;                                    // [RULE18]
      end
   end

   always_comb begin
      stat_clr_a = i_reg_wr & (i_reg_addr == ars_pkg::ADDR_STAT)
                   & i_reg_wdata[ars_pkg::STAT_A_BIT];
      stat_clr_b = i_reg_wr & (i_reg_addr == ars_pkg::ADDR_STAT)
                   & i_reg_wdata[ars_pkg::STAT_B_BIT];
   end

   always_comb begin
      next_st = st;
      // Accumulators take the adder result as is: no saturation here
      if (i_add_valid && !i_add_target) begin
         next_st.acc_a = i_add_result;                                     // [RULE1] [RULE13]
      end
      if (i_add_valid && i_add_target) begin
         next_st.acc_b = i_add_result;                                     // [RULE1]
      end
      // Set beats a same-cycle software clear
      if (stat_clr_a) begin
         next_st.acc_a_saturation_flag = 1'b0;                             // [RULE22]
      end
      if (stat_clr_b) begin
         next_st.acc_b_saturation_flag = 1'b0;                             // [RULE22]
      end
      if (i_add_valid && i_add_ovf39 && !i_add_target) begin
         next_st.acc_a_saturation_flag = 1'b1;                             // [RULE1] [RULE22]
      end
      if (i_add_valid && i_add_ovf39 && i_add_target) begin
         next_st.acc_b_saturation_flag = 1'b1;                             // [RULE1] [RULE22]
      end
      next_st.trap_req = i_add_valid & i_add_ovf39 & st.catastrophic_trap_enable; // [RULE2]

      // Register port
      next_st.rdata = 32'h00000000;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            ars_pkg::ADDR_CFG: begin
               next_st.rdata[ars_pkg::CFG_ROUND_BIT] = st.round_mode_select;
               next_st.rdata[ars_pkg::CFG_STSAT_BIT] = st.store_saturate_enable;
               next_st.rdata[ars_pkg::CFG_TRAP_BIT]  = st.catastrophic_trap_enable;
            end
            ars_pkg::ADDR_STAT: begin
               next_st.rdata[ars_pkg::STAT_A_BIT]  = st.acc_a_saturation_flag;
               next_st.rdata[ars_pkg::STAT_B_BIT]  = st.acc_b_saturation_flag;
               next_st.rdata[ars_pkg::STAT_AB_BIT] = st.acc_a_saturation_flag
                                                      | st.acc_b_saturation_flag;
            end
            ars_pkg::ADDR_WBPTR: next_st.rdata = {16'h0000, st.writeback_pointer_reg};
            default:             next_st.rdata = 32'h00000000;
         endcase
      end
      if (i_reg_wr && (i_reg_addr == ars_pkg::ADDR_CFG)) begin
         next_st.round_mode_select        = i_reg_wdata[ars_pkg::CFG_ROUND_BIT]; // [RULE7]
         next_st.store_saturate_enable    = i_reg_wdata[ars_pkg::CFG_STSAT_BIT];
         next_st.catastrophic_trap_enable = i_reg_wdata[ars_pkg::CFG_TRAP_BIT];  // [RULE2]
      end
      // Software pointer write loses to a same-cycle write-back update
      if (i_reg_wr && (i_reg_addr == ars_pkg::ADDR_WBPTR)) begin
         next_st.writeback_pointer_reg = i_reg_wdata[15:0];
      end

      // Data-space write path
      next_st.xwr_valid = 1'b0;
      next_st.xwr_addr  = st.xwr_addr;
      next_st.xwr_data  = st.xwr_data;
      if (i_store_valid) begin
         next_st.xwr_valid = 1'b1;                                         // [RULE11]
         next_st.xwr_addr  = i_store_addr;
         next_st.xwr_data  = store_word;                                   // [RULE13]
      end else if (wb_allowed && (i_mac_wb_mode == ars_pkg::ARS_WB_POSTINC)) begin
         next_st.xwr_valid = 1'b1;                                         // [RULE4]
         next_st.xwr_addr  = st.writeback_pointer_reg;                     // [RULE6]
         next_st.xwr_data  = wb_word;
         next_st.writeback_pointer_reg = st.writeback_pointer_reg
                                         + ars_pkg::WBPTR_STEP;            // [RULE6]
      end else if (wb_allowed) begin
         next_st.writeback_pointer_reg = wb_word;                          // [RULE5]
      end

      // Shifter result
      next_st.sh_valid = i_sh_valid;
      if (i_sh_valid) begin
         next_st.sh_result = sh_out;                                       // [RULE20]
         next_st.sh_word   = sh_left ? sh_out[15:0] : sh_out[31:16];       // [RULE20] [RULE21]
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         st                          <= '0;
         st.round_mode_select        <= ars_pkg::CFG_RSEL_RESET;
         st.store_saturate_enable    <= ars_pkg::CFG_SAT_RESET;
         st.catastrophic_trap_enable <= ars_pkg::CFG_TRAP_RESET;
         st.writeback_pointer_reg    <= ars_pkg::WBPTR_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign o_reg_rdata             = st.rdata;
   assign o_xwr_valid             = st.xwr_valid;
   assign o_xwr_addr              = st.xwr_addr;
   assign o_xwr_data              = st.xwr_data;
   assign o_trap_req              = st.trap_req;
   assign o_acc_a_saturation_flag = st.acc_a_saturation_flag;
   assign o_acc_b_saturation_flag = st.acc_b_saturation_flag;
   assign o_sh_valid              = st.sh_valid;
   assign o_sh_result             = st.sh_result;
   assign o_sh_word               = st.sh_word;

   default clocking ars_cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   logic mac_excluded;
   assign mac_excluded = (i_mac_op == ars_pkg::ARS_OP_MUL) | (i_mac_op == ars_pkg::ARS_OP_MULN)
                         | (i_mac_op == ars_pkg::ARS_OP_SQD) | (i_mac_op == ars_pkg::ARS_OP_SQDAC);

   cat_flag_set_a: assert property (
      i_add_valid && !i_add_target && i_add_ovf39 |=> st.acc_a_saturation_flag
         && st.acc_a == $past(i_add_result))                               // [RULE1]
      else $error("bit 39 overflow did not set flag or wrap acc A");
   flag_sticky_a: assert property (
      st.acc_a_saturation_flag && !stat_clr_a |=> st.acc_a_saturation_flag) // [RULE22]
      else $error("acc A flag dropped without software clear");
   flag_sticky_b_a: assert property ( // [RULE22]
      st.acc_b_saturation_flag && !stat_clr_b |=> st.acc_b_saturation_flag)
      else $error("acc B flag dropped without software clear");
   round_wrap_a: assert property ( // [RULE15]
      i_store_valid && i_store_round && store_acc[39:15] == 25'h1FFFFFF
         |=> o_xwr_data == 16'h0000)
      else $error("negative value rounding to zero was clamped");
   trap_request_a: assert property (
      i_add_valid && i_add_ovf39 |=> o_trap_req == $past(st.catastrophic_trap_enable))
      else $error("trap request does not follow enable");                  // [RULE2]
   excluded_wb_a: assert property (
      i_mac_valid && mac_excluded && !i_store_valid |=> !o_xwr_valid
         && $stable(st.writeback_pointer_reg) or $past(i_reg_wr))          // [RULE3]
      else $error("excluded operation produced write-back");
   postinc_ptr_a: assert property (
      wb_allowed && i_mac_wb_mode == ars_pkg::ARS_WB_POSTINC |=> o_xwr_valid
         && o_xwr_addr == $past(st.writeback_pointer_reg)
         && st.writeback_pointer_reg == $past(st.writeback_pointer_reg) + 16'h0002)
      else $error("post-increment write-back wrong");                      // [RULE6]
   sat_positive_a: assert property (
      i_store_valid && st.store_saturate_enable && !store_acc[39]
         && store_acc[38:31] != 8'h00 |=> o_xwr_data == 16'h7FFF)          // [RULE14]
      else $error("positive store not clamped");
   sat_negative_a: assert property (
      i_store_valid && st.store_saturate_enable && store_acc[39]
         && store_acc[38:31] != 8'hFF |=> o_xwr_data == 16'h8000)          // [RULE15]
      else $error("negative store not clamped");
   trunc_store_a: assert property (
      i_store_valid && !i_store_round && !st.store_saturate_enable
         |=> o_xwr_data == $past(store_acc[31:16]))                        // [RULE8]
      else $error("truncated store wrong");
   conv_round_a: assert property (
      i_store_valid && i_store_round && !st.store_saturate_enable && !st.round_mode_select
         |=> o_xwr_data == 16'($past(store_acc[31:16]) + {15'h0000, $past(store_acc[15])}))
      else $error("conventional rounding wrong");                          // [RULE9]
   shift_zero_a: assert property (
      i_sh_valid && i_sh_amount == 6'h00 && i_sh_src == ars_pkg::ARS_SRC_ACC_A
         |=> o_sh_valid && o_sh_result == $past(st.acc_a))                 // [RULE19]
      else $error("zero shift changed operand");
   sat_keeps_acc_a: assert property (
      i_store_valid && !i_add_valid |=> $stable(st.acc_a) && $stable(st.acc_b))
      else $error("store altered an accumulator");                         // [RULE13]

   cover_trap: cover property (i_add_valid && i_add_ovf39 ##1 o_trap_req);
   cover_postinc: cover property (wb_allowed && i_mac_wb_mode == ars_pkg::ARS_WB_POSTINC);
   cover_sat_store: cover property (i_store_valid && st.store_saturate_enable
                                    && store_acc[39] ##1 o_xwr_data == 16'h8000);
   cover_left_shift: cover property (i_sh_valid && i_sh_amount[5]);
   cover_direct_wb: cover property (wb_allowed && i_mac_wb_mode == ars_pkg::ARS_WB_DIRECT);

endmodule : ars_engine

// [verification/ars_mem_model.sv]
`timescale 1ns/1ps
module ars_mem_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_xwr_valid,
   input  wire logic [15:0] i_xwr_addr,
   input  wire logic [15:0] i_xwr_data,
   output int               o_wr_count
);
   // Sparse store of the whole X and Y space; only written words exist
   logic [15:0] mem [logic [15:0]];

   // Single write path, any address accepted
   always @(posedge i_clk_sys) begin
      if (i_xwr_valid) begin
         mem[i_xwr_addr] = i_xwr_data;
         o_wr_count = o_wr_count + 1;
      end
   end
endmodule : ars_mem_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
   logic                  clk = 1'b0;
   logic                  rstn = 1'b0;
   logic [7:0]            ra;
   logic [31:0]           wd, rdata;
   logic                  wr, rd, av, at, aovf, sv, sr, st, mv, mt, mwe, hv, har;
   logic [39:0]           ares, shr;
   logic [15:0]           saddr, hx, xa, xd, shw, ptr;
   logic [5:0]            ham;
   logic                  xv, trap, fa, fb, shv;
   ars_pkg::ars_mac_op_t  mop;
   ars_pkg::ars_wb_mode_t mmd;
   ars_pkg::ars_sh_src_t  hsrc;
   int                    wr_count, nwr;
   int                    err_count = 0;
   int                    check_count = 0;
   logic [39:0]           acc [2];
   logic [2:0]            cfg;
   logic [1:0]            flg;
   logic [15:0]           shadow [logic [15:0]];
   logic [15:0]           lows [4] = '{16'h7FFF, 16'h8000, 16'h8001, 16'hFFFF};
   logic [39:0]           satv [6] = '{40'h00_7FFF_8000, 40'h00_8000_0000, 40'hFF_7FFF_0000,
                                       40'hFF_8000_0000, 40'hFF_FFFF_8000, 40'h01_0000_0000};
   logic [5:0]            amts [9] = '{6'h00, 6'h01, 6'h0F, 6'h10, 6'h3F, 6'h30, 6'h31,
                                       6'h1F, 6'h20};

   always #10 clk = ~clk;

   ars_engine DUT (
      .i_clk_sys(clk), .i_resetn(rstn), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .i_add_valid(av), .i_add_target(at),
      .i_add_result(ares), .i_add_ovf39(aovf), .i_store_valid(sv), .i_store_round(sr),
      .i_store_target(st), .i_store_addr(saddr), .i_mac_valid(mv), .i_mac_op(mop),
      .i_mac_target(mt), .i_mac_wb_en(mwe), .i_mac_wb_mode(mmd), .i_sh_valid(hv),
      .i_sh_src(hsrc), .i_sh_arith(har), .i_sh_amount(ham), .i_sh_xdata(hx),
      .o_xwr_valid(xv), .o_xwr_addr(xa), .o_xwr_data(xd), .o_trap_req(trap),
      .o_acc_a_saturation_flag(fa), .o_acc_b_saturation_flag(fb), .o_sh_valid(shv),
      .o_sh_result(shr), .o_sh_word(shw));

   ars_mem_model u_mem (.i_clk_sys(clk), .i_xwr_valid(xv), .i_xwr_addr(xa),
                        .i_xwr_data(xd), .o_wr_count(wr_count));

   // Full signed value kept so a round carry past 0x7FFF still clamps
   function automatic logic [15:0] st_word(input logic [39:0] a, input logic r);
      logic               inc;
      logic signed [24:0] v;
      inc = r && (a[15:0] > 16'h8000 || (a[15:0] == 16'h8000 && (!cfg[0] || a[16])));
      v = $signed({a[39], a[39:16]}) + $signed({24'h0, inc});
      if (cfg[1] && v > 25'sh007FFF) return 16'h7FFF;
      if (cfg[1] && v < -25'sh8000) return 16'h8000;
      return v[15:0];
   endfunction : st_word

   function automatic logic [39:0] sh_exp(input logic [1:0] s, input logic ar,
                                          input logic [5:0] am, input logic [15:0] x);
      logic [39:0] op;
      int          n;
      n = $signed(am);
      if (n > 16) n = 16;
      if (n < -16) n = -16;
      case (s)
         2'h0: op = acc[0];
         2'h1: op = acc[1];
         2'h2: op = (n < 0) ? {24'h0, x} : {{8{ar & x[15]}}, x, 16'h0};
         default: op = '0;
      endcase
      if (n < 0) return op << (-n);
      return ar ? 40'($signed(op) >>> n) : op >> n;
   endfunction : sh_exp

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk); ra <= a; wd <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string m);
      @(posedge clk); ra <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0; #1;
      chk(rdata, e, m);
   endtask : reg_rd

   task automatic set_cfg(input logic [2:0] c);
      reg_wr(ars_pkg::ADDR_CFG, {29'h0, c});
      cfg = c;
   endtask : set_cfg

   task automatic add_op(input logic t, input logic [39:0] v, input logic ov);
      @(posedge clk); av <= 1'b1; at <= t; ares <= v; aovf <= ov;
      @(posedge clk); av <= 1'b0; #1;
      acc[t] = v;
      if (ov) flg[t] = 1'b1;
      chk(trap, ov & cfg[2], "trap");
      chk({fb, fa}, flg, "flags");
   endtask : add_op

   task automatic store(input logic r, input logic t, input logic [15:0] a);
      logic [15:0] e;
      e = st_word(acc[t], r);
      @(posedge clk); sv <= 1'b1; sr <= r; st <= t; saddr <= a;
      @(posedge clk); sv <= 1'b0; #1;
      chk({xv, xa, xd}, {1'b1, a, e}, "store");
      shadow[a] = e;
      nwr++;
   endtask : store

   task automatic mac(input logic [2:0] op, input logic t, input logic we, input logic md);
      logic [15:0] e;
      logic        go;
      go = we && op < 3'h4;
      e = st_word(acc[~t], 1'b1);
      @(posedge clk); mv <= 1'b1; mop <= ars_pkg::ars_mac_op_t'(op); mt <= t;
      mwe <= we; mmd <= ars_pkg::ars_wb_mode_t'(md);
      @(posedge clk); mv <= 1'b0; #1;
      chk(xv, go & md, "wb valid");
      if (go & md) begin
         chk({xa, xd}, {ptr, e}, "wb write");
         shadow[ptr] = e;
         nwr++;
         ptr = ptr + 16'h2;
      end else if (go) begin
         ptr = e;
      end
   endtask : mac

   task automatic shift(input logic [1:0] s, input logic ar, input logic [5:0] am,
                        input logic [15:0] x);
      logic [39:0] e;
      e = sh_exp(s, ar, am, x);
      @(posedge clk); hv <= 1'b1; hsrc <= ars_pkg::ars_sh_src_t'(s); har <= ar;
      ham <= am; hx <= x;
      @(posedge clk); hv <= 1'b0; #1;
      chk({shv, shr, shw}, {1'b1, e, am[5] ? e[15:0] : e[31:16]}, "shift");
   endtask : shift

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   // Whole run is under a thousand cycles; this leaves ample margin
   initial begin
      #400_000;
      err_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      finish_test;
   end

   initial begin
      {ra, wd, wr, rd, av, at, aovf, ares, sv, sr, st, saddr} = '0;
      {mv, mt, mwe, hv, har, ham, hx} = '0;
      mop = ars_pkg::ARS_OP_MAC;
      mmd = ars_pkg::ARS_WB_DIRECT;
      hsrc = ars_pkg::ARS_SRC_ACC_A;
      acc[0] = '0;
      acc[1] = '0;
      {cfg, flg, ptr, nwr} = '0;
      void'($urandom(32'h8D85));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      reg_rd(ars_pkg::ADDR_CFG, 32'h0, "cfg reset");
      reg_rd(ars_pkg::ADDR_STAT, 32'h0, "stat reset");
      reg_rd(ars_pkg::ADDR_WBPTR, 32'h0, "ptr reset");
      reg_wr(8'h0C, 32'hFFFF_FFFF);
      reg_rd(8'h0C, 32'h0, "unmapped");
      $display("test registers done");
      set_cfg(3'h4);
      add_op(1'b0, 40'h80_0000_0000, 1'b1);
      store(1'b0, 1'b0, 16'h0100);
      add_op(1'b0, 40'h00_1234_0000, 1'b0);
      set_cfg(3'h0);
      add_op(1'b1, 40'h7F_FFFF_FFFF, 1'b1);
      reg_rd(ars_pkg::ADDR_STAT, 32'h7, "stat both");
      reg_wr(ars_pkg::ADDR_STAT, 32'h1);
      flg = 2'h2;
      reg_rd(ars_pkg::ADDR_STAT, 32'h6, "stat a cleared");
      reg_wr(ars_pkg::ADDR_STAT, 32'h2);
      flg = 2'h0;
      reg_rd(ars_pkg::ADDR_STAT, 32'h0, "stat cleared");
      $display("test overflow done");
      for (int i = 0; i < 32; i++) begin
         set_cfg({2'h0, i[3]});
         add_op(i[0], {8'h00, 15'h2191, i[0], lows[i[2:1]]}, 1'b0);
         store(i[4], i[0], 16'h0200 + 16'(2 * i));
      end
      $display("test rounding done");
      for (int i = 0; i < 6; i++) begin
         set_cfg(3'h2);
         add_op(1'b1, satv[i], 1'b0);
         store(1'b1, 1'b1, 16'h0300 + 16'(4 * i));
         set_cfg(3'h0);
         store(1'b0, 1'b1, 16'h0302 + 16'(4 * i));
      end
      $display("test saturation done");
      reg_wr(ars_pkg::ADDR_WBPTR, 32'h0000_1000);
      ptr = 16'h1000;
      for (int i = 0; i < 32; i++) begin
         set_cfg(3'($urandom) & 3'h3);
         add_op(~i[4], 40'({$urandom, $urandom}), 1'b0);
         mac(i[2:0], i[4], ~(i[4] & i[0]), i[3]);
      end
      reg_rd(ars_pkg::ADDR_WBPTR, {16'h0, ptr}, "ptr after wb");
      $display("test write back done");
      for (int i = 0; i < 40; i++) begin
         set_cfg(3'($urandom));
         add_op(i[0], 40'({$urandom, $urandom}), ($urandom % 8) == 0);
         store(1'($urandom), 1'($urandom), 16'($urandom) & 16'hFFFE);
      end
      $display("test random store done");
      for (int i = 0; i < 72; i++)
         shift(2'(i), i[2], amts[i / 8], 16'($urandom));
      for (int i = 0; i < 30; i++)
         shift(2'($urandom), 1'($urandom), 6'($urandom_range(0, 32) - 16), 16'($urandom));
      $display("test shifter done");
      repeat (2) @(posedge clk);
      foreach (shadow[k]) chk(u_mem.mem[k], shadow[k], "memory word");
      chk(32'(wr_count), 32'(nwr), "write count");
      $display("test memory done");
      finish_test;
   end
endmodule : tb
